// *** iwcd_pkg.sv ***
// constants and carrier types of the idle wake and clock divider block
// assumes a classic wishbone master with 32-bit data, one clock domain
//
// Contract
// RULE1: watchdog interrupt ends idle only when wake enable bit 2 is set
// RULE2: external interrupt 1 ends idle only when wake enable bit 1 set
// RULE3: external interrupt 0 ends idle only when wake enable bit 0 set
// RULE4: auxiliary interrupts always wake, gated only by auxiliary enable bit
// RULE5: mode 00 selects undivided normal operation, the reset state
// RULE6: mode 01 divides at once, leaves on wake-up or normal write
// RULE7: delay mode, tick enabled: divide from next tick to following tick
// RULE8: delay mode, tick masked: start at next tick, end at tick after wake
// RULE9: normal mode write ends delay mode division too
// RULE10: mode 11 divides until mode rewritten, ignoring wake-ups and ticks
// RULE11: mode field reads status: 00 none, 01 immediate, 10 delay
// RULE12: select codes 000-100 divide 2..32, 101-111 divide 1024..4096
// RULE13: divided and undivided clock switch only on whole clock boundaries
// RULE14: unused register bits read fixed zero and ignore writes
package iwcd_pkg;

   // ==========================================================
   // register map (indices; byte address is four times index)
   localparam int IWCD_ADR_W = 10;
   localparam logic [7:0] IWCD_IDX_WAKE = 8'hC6;
   localparam logic [7:0] IWCD_IDX_RATIO = 8'hC7;
   localparam logic [7:0] IWCD_WAKE_RST = 8'h00;
   localparam logic [7:0] IWCD_RATIO_RST = 8'h00;

   // ==========================================================
   // field positions
   localparam int IWCD_WAKE_WDT_BIT = 2;
   localparam int IWCD_WAKE_EX1_BIT = 1;
   localparam int IWCD_WAKE_EX0_BIT = 0;
   localparam int IWCD_MODE_LSB = 4;
   localparam int IWCD_SEL_LSB = 0;

   // ==========================================================
   // mode codes, written and read
   localparam logic [1:0] IWCD_MODE_NORMAL = 2'h0;
   localparam logic [1:0] IWCD_MODE_IMM = 2'h1;
   localparam logic [1:0] IWCD_MODE_DELAY = 2'h2;
   localparam logic [1:0] IWCD_MODE_MANUAL = 2'h3;

   // ==========================================================
   // divider
   localparam int IWCD_CNT_W = 12;
   localparam logic [2:0] IWCD_SEL_RST = 3'h0;

   typedef struct packed {
      logic wdt;
      logic ex1;
      logic ex0;
   } iwcd_wake_t;

   typedef struct packed {
      logic wdt;
      logic ex1;
      logic ex0;
      logic aux;
   } iwcd_irq_t;

   typedef enum logic [2:0] {
      IWCD_ST_NORMAL,
      IWCD_ST_IMM,
      IWCD_ST_DLY_WAIT,
      IWCD_ST_DLY_DIV,
      IWCD_ST_DLY_ARM,
      IWCD_ST_MANUAL
   } iwcd_state_t;

endpackage

// *** iwcd_top.sv ***
// idle wake-up gating and cpu clock divider with wishbone register access
// assumes interrupt, idle and tick inputs come from logic on clk_i
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module iwcd_top
   import iwcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [IWCD_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic idle_i,
   input wire iwcd_irq_t irq_i,
   input wire logic aux_irq_enable_i,
   input wire logic ms_tick_i,
   input wire logic ms_tick_en_i,
   output logic wake_o,
   output logic cpu_clk_en_o,
   output logic div_active_o
);

   // ==========================================================
   // bus decode
   logic req;
   logic hit_wake;
   logic hit_ratio;
   logic wr_ratio;
   logic [1:0] wr_mode;
   iwcd_wake_t wake_en;
   iwcd_state_t state;
   iwcd_state_t next_state;
   logic [2:0] ratio_sel;
   logic [1:0] mode_status;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_wake = wb_adr_i == {IWCD_IDX_WAKE, 2'h0};
   assign hit_ratio = wb_adr_i == {IWCD_IDX_RATIO, 2'h0};
   assign wr_ratio = req & wb_we_i & wb_sel_i[0] & hit_ratio;
   assign wr_mode = wb_dat_i[IWCD_MODE_LSB +: 2];

   // single registered ack one cycle after the request; unmapped addresses ack with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req & ~wb_we_i) begin
         wb_dat_o <= 32'h0000_0000;
         if (hit_wake) begin
            wb_dat_o[2:0] <= wake_en; // RULE14
         end else if (hit_ratio) begin
            wb_dat_o[IWCD_MODE_LSB +: 2] <= mode_status; // RULE11
            wb_dat_o[IWCD_SEL_LSB +: 3] <= ratio_sel; // RULE14
         end
      end
   end

   // ==========================================================
   // register storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_en <= iwcd_wake_t'(IWCD_WAKE_RST[2:0]);
      end else if (req & wb_we_i & wb_sel_i[0] & hit_wake) begin
         wake_en <= iwcd_wake_t'(wb_dat_i[2:0]); // RULE14
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ratio_sel <= IWCD_SEL_RST;
      end else if (wr_ratio) begin
         ratio_sel <= wb_dat_i[IWCD_SEL_LSB +: 3]; // RULE12
      end
   end

   // ==========================================================
   // wake-up condition
   logic wake_cond;

   assign wake_cond = idle_i & ((irq_i.wdt & wake_en.wdt) // RULE1
      | (irq_i.ex1 & wake_en.ex1) // RULE2
      | (irq_i.ex0 & wake_en.ex0) // RULE3
      | (irq_i.aux & aux_irq_enable_i)); // RULE4

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= wake_cond;
      end
   end

   // ==========================================================
   // divide mode sequencing; a write always beats a same-cycle event
   always_comb begin
      next_state = state;
      if (wr_ratio) begin
         case (wr_mode)
            IWCD_MODE_NORMAL: next_state = IWCD_ST_NORMAL; // RULE5 RULE9
            IWCD_MODE_IMM: next_state = IWCD_ST_IMM; // RULE6
            IWCD_MODE_DELAY: next_state = IWCD_ST_DLY_WAIT;
            default: next_state = IWCD_ST_MANUAL; // RULE10
         endcase
      end else begin
         case (state)
            IWCD_ST_IMM: begin
               if (wake_cond) begin
                  next_state = IWCD_ST_NORMAL; // RULE6
               end
            end
            IWCD_ST_DLY_WAIT: begin
               // raw tick condition, counted even when masked
               if (ms_tick_i) begin
                  next_state = IWCD_ST_DLY_DIV; // RULE7 RULE8
               end
            end
            IWCD_ST_DLY_DIV: begin
               if (ms_tick_en_i & ms_tick_i) begin
                  next_state = IWCD_ST_NORMAL; // RULE7
               end else if (~ms_tick_en_i & wake_cond) begin
                  next_state = IWCD_ST_DLY_ARM; // RULE8
               end
            end
            IWCD_ST_DLY_ARM: begin
               if (ms_tick_i) begin
                  next_state = IWCD_ST_NORMAL; // RULE8
               end
            end
            default: next_state = state; // RULE10
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= IWCD_ST_NORMAL; // RULE5
      end else begin
         state <= next_state;
      end
   end

   // manual reports the reserved code so software can still tell it apart
   always_comb begin
      case (state)
         IWCD_ST_NORMAL: mode_status = IWCD_MODE_NORMAL;
         IWCD_ST_IMM: mode_status = IWCD_MODE_IMM;
         IWCD_ST_MANUAL: mode_status = IWCD_MODE_MANUAL;
         default: mode_status = IWCD_MODE_DELAY;
      endcase
   end

   // ==========================================================
   // divider: enable strobe, switched only at the end of a whole period
   logic div_req;
   logic div_on;
   logic [2:0] div_sel;
   logic [IWCD_CNT_W-1:0] cnt;
   logic [IWCD_CNT_W-1:0] next_cnt;
   logic next_div_on;
   logic [2:0] next_div_sel;
   logic [IWCD_CNT_W-1:0] last;
   logic [IWCD_CNT_W-1:0] next_last;

   function automatic logic [IWCD_CNT_W-1:0] ratio_last(input logic [2:0] s);
      logic [3:0] sh;
      sh = (s > 3'h4) ? 4'(s) + 4'h5 : 4'(s) + 4'h1;
      ratio_last = IWCD_CNT_W'((13'h0001 << sh) - 13'h0001); // RULE12
   endfunction

   assign div_req = (state == IWCD_ST_IMM) | (state == IWCD_ST_DLY_DIV)
      | (state == IWCD_ST_DLY_ARM) | (state == IWCD_ST_MANUAL);
   assign last = ratio_last(div_sel);
   assign next_last = ratio_last(next_div_sel);

   // a period in progress always runs to its end, so no runt cpu cycle
   always_comb begin
      next_cnt = cnt;
      next_div_on = div_on;
      next_div_sel = div_sel;
      if (~div_on | (cnt == last)) begin
         next_cnt = '0; // RULE13
         next_div_on = div_req;
         next_div_sel = ratio_sel;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
         div_on <= 1'b0;
         div_sel <= IWCD_SEL_RST;
      end else begin
         cnt <= next_cnt;
         div_on <= next_div_on;
         div_sel <= next_div_sel;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clk_en_o <= 1'b1;
         div_active_o <= 1'b0;
      end else begin
         cpu_clk_en_o <= ~next_div_on | (next_cnt == next_last); // RULE13
         div_active_o <= next_div_on;
      end
   end

   // ==========================================================
   // checks
   wake_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_i & irq_i.wdt & wake_en.wdt) |=> wake_o) // RULE1
      else $error("watchdog wake missed");

   ex1_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (~irq_i.wdt & ~irq_i.ex0 & ~irq_i.aux & irq_i.ex1 & ~wake_en.ex1) |=> ~wake_o) // RULE2
      else $error("masked ext1 woke");

   ex0_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_i & irq_i.ex0 & wake_en.ex0) |=> wake_o) // RULE3
      else $error("ext0 wake missed");

   aux_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_i & irq_i.aux & aux_irq_enable_i) |=> wake_o) // RULE4
      else $error("aux wake missed");

   normal_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_NORMAL && !div_on) [*2] |=> cpu_clk_en_o) // RULE5
      else $error("normal mode divided");

   imm_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_IMM && !wr_ratio && wake_cond) |=> state == IWCD_ST_NORMAL) // RULE6
      else $error("immediate mode kept after wake");

   delay_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_DLY_WAIT && !wr_ratio && ms_tick_i) |=> state == IWCD_ST_DLY_DIV) // RULE7
      else $error("delay start missed");

   delay_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_DLY_DIV && !wr_ratio && !ms_tick_en_i && ms_tick_i && !wake_cond)
      |=> state == IWCD_ST_DLY_DIV) // RULE8
      else $error("masked tick ended delay early");

   delay_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_DLY_DIV && !wr_ratio && ms_tick_en_i && ms_tick_i)
      |=> state == IWCD_ST_NORMAL) // RULE7
      else $error("enabled tick did not end delay");

   armed_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_DLY_ARM && !wr_ratio && ms_tick_i)
      |=> state == IWCD_ST_NORMAL) // RULE8
      else $error("armed delay kept after tick");

   // a longest period of 4096 cycles may still have to run out after a normal write
   localparam logic [IWCD_CNT_W:0] STOP_ONE = {{IWCD_CNT_W{1'b0}}, 1'b1};
   localparam logic [IWCD_CNT_W:0] STOP_MAX = {1'b1, {(IWCD_CNT_W - 1){1'b0}}, 1'b1};
   logic [IWCD_CNT_W:0] stop_wait;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_wait <= '0;
      end else if (wr_ratio) begin
         if (wr_mode == IWCD_MODE_NORMAL) begin
            stop_wait <= STOP_ONE; // RULE9
         end else begin
            stop_wait <= '0;
         end
      end else if ((stop_wait != '0) & div_active_o) begin
         stop_wait <= stop_wait + 1'b1;
      end else begin
         stop_wait <= '0;
      end
   end

   normal_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_wait <= STOP_MAX) // RULE9
      else $error("normal write did not stop divide");

   manual_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == IWCD_ST_MANUAL && !wr_ratio) |=> state == IWCD_ST_MANUAL) // RULE10
      else $error("manual mode left without write");

   status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_ratio && state == IWCD_ST_IMM)
      |=> wb_ack_o && wb_dat_o[5:4] == 2'h1) // RULE11
      else $error("status read wrong");

   div2_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (div_on && div_sel == 3'h0 && div_req && cpu_clk_en_o) |=> !cpu_clk_en_o) // RULE12
      else $error("divide by two period wrong");

   no_runt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (div_on && cnt != last) |=> div_on) // RULE13
      else $error("divided period cut short");

   fixed_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o[31:6] == 26'h0 && wb_dat_o[3] == 1'b0)) // RULE14
      else $error("unused bits not zero");

endmodule

// *** iwcd_core_model.sv ***
// core side model: idle flag, interrupt lines and raw tick pulse
// assumes the bench asks for sleep and tick by one-cycle strobes and holds interrupt requests as levels, on clk_i
`timescale 1ns/1ps
module iwcd_core_model
   import iwcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sleep_i,
   input wire logic [3:0] irq_req_i,
   input wire logic tick_req_i,
   input wire logic wake_i,
   output logic idle_o,
   output iwcd_irq_t irq_o,
   output logic ms_tick_o
);
   // ==========================================
   // idle state: only a wake request ends it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_o <= 1'b0;
      end else if (wake_i) begin
         idle_o <= 1'b0;
      end else if (sleep_i) begin
         idle_o <= 1'b1;
      end
   end
   // ==========================================
   // events: tick is the raw overflow, shown even when masked
   always_ff @(posedge clk_i) begin
      irq_o <= rst_i ? 4'h0 : irq_req_i;
      ms_tick_o <= !rst_i && tick_req_i;
   end
endmodule

// *** tb_idle_wake_and_clock_divider.sv ***
// bench: wishbone register tasks, wake and divider scenarios
// assumes the core model beside the design and one 50 MHz clock
`timescale 1ns/1ps
module tb_idle_wake_and_clock_divider;
   import iwcd_pkg::*;
   localparam logic [9:0] AW = {IWCD_IDX_WAKE, 2'h0};
   localparam logic [9:0] AR = {IWCD_IDX_RATIO, 2'h0};
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, idle, tick, tick_en = 1'b0, aux_en = 1'b0, wake, clk_en, div;
   logic sleep = 1'b0, tick_req = 1'b0;
   logic [3:0] irq_req = 4'h0;
   iwcd_irq_t irq;
   int n_mismatch = 0, samples_checked = 0, wakes = 0, cycles = 0, w0;
   iwcd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .idle_i(idle), .irq_i(irq), .aux_irq_enable_i(aux_en),
      .ms_tick_i(tick), .ms_tick_en_i(tick_en), .wake_o(wake), .cpu_clk_en_o(clk_en),
      .div_active_o(div));
   iwcd_core_model core (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep),
      .irq_req_i(irq_req), .tick_req_i(tick_req), .wake_i(wake), .idle_o(idle),
      .irq_o(irq), .ms_tick_o(tick));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // ==========================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // request held until ack is sampled, released at that edge
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      wb(1'b0, a, 8'h00);
      chk("reg_read", q, e);
   endtask
   task automatic wait_div(input logic e, input int lim);
      for (int i = 0; i < lim && div !== e; i++) @(posedge clk_i);
      chk("div_active", {31'h0, div}, {31'h0, e});
   endtask
   task automatic per(input int e);
      int n;
      n = 0;
      do @(posedge clk_i); while (clk_en !== 1'b1);
      do begin
         @(posedge clk_i);
         n++;
      end while (clk_en !== 1'b1 && n < 5000);
      chk("clk_period", n, e);
   endtask
   task automatic pulse_tick();
      @(posedge clk_i);
      tick_req <= 1'b1;
      @(posedge clk_i);
      tick_req <= 1'b0;
   endtask
   task automatic nap(input logic [3:0] v);
      @(posedge clk_i);
      sleep <= 1'b1;
      irq_req <= v;
      @(posedge clk_i);
      sleep <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(AW, 32'h0);
      rd(AR, 32'h0);
      per(1);
      wb(1'b1, AW, 8'hFF);
      rd(AW, 32'h07);
      rd(10'h000, 32'h0);
      // one source at a time: masked first, then enabled
      for (int s = 0; s < 4; s++) begin
         wb(1'b1, AW, 8'h00);
         aux_en <= 1'b0;
         nap(4'h8 >> s);
         w0 = wakes;
         repeat (6) @(posedge clk_i);
         chk("no_wake", wakes - w0, 0);
         if (s < 3) wb(1'b1, AW, 8'h04 >> s);
         else aux_en <= 1'b1;
         repeat (4) @(posedge clk_i);
         chk("wake", {31'h0, wakes != w0}, 1);
         irq_req <= 4'h0;
      end
      for (int k = 0; k < 8; k++) begin
         wb(1'b1, AR, 8'hD8 | 8'(k));
         wait_div(1'b1, 10);
         per(k < 5 ? 2 << k : 1024 << (k - 5));
         rd(AR, 32'h10 | 32'(k));
         wb(1'b1, AR, 8'h00);
         wait_div(1'b0, 4200);
         per(1);
      end
      wb(1'b1, AW, 8'h01);
      wb(1'b1, AR, 8'h11);
      wait_div(1'b1, 10);
      nap(4'h2);
      wait_div(1'b0, 20);
      rd(AR, 32'h01);
      wb(1'b1, AR, 8'h30);
      wait_div(1'b1, 10);
      nap(4'h2);
      pulse_tick();
      repeat (20) @(posedge clk_i);
      chk("manual_hold", {31'h0, div}, 1);
      rd(AR, 32'h30);
      wb(1'b1, AR, 8'h00);
      wait_div(1'b0, 20);
      irq_req <= 4'h0;
      tick_en <= 1'b1;
      wb(1'b1, AR, 8'h20);
      repeat (10) @(posedge clk_i);
      chk("delay_wait", {31'h0, div}, 0);
      rd(AR, 32'h20);
      pulse_tick();
      wait_div(1'b1, 6);
      pulse_tick();
      wait_div(1'b0, 6);
      tick_en <= 1'b0;
      wb(1'b1, AR, 8'h20);
      pulse_tick();
      wait_div(1'b1, 6);
      pulse_tick();
      repeat (6) @(posedge clk_i);
      chk("masked_hold", {31'h0, div}, 1);
      nap(4'h2);
      repeat (6) @(posedge clk_i);
      chk("armed_hold", {31'h0, div}, 1);
      pulse_tick();
      wait_div(1'b0, 6);
      irq_req <= 4'h0;
      wb(1'b1, AR, 8'h20);
      pulse_tick();
      wait_div(1'b1, 6);
      wb(1'b1, AR, 8'h00);
      wait_div(1'b0, 6);
      rd(AR, 32'h0);
      wrap_up();
   end
endmodule
